/* File: verilog/blp_bus_lane_parity.sv */
// blp_bus_lane_parity.sv: address/byte-lane drive, write data and parity, read parity status
// assumes: one 40 MHz clock; bus inputs synchronous; ready arrives from the system controller
//
// Summary of operation
// - every bus input sampled and output launched on core clock rising edge.
// - location is word address lines 31..2 plus four low byte lane selects.
// - system may drive address 31..4 in as a cache line invalidate address.
// - address outputs float during bus hold or address hold.
// - byte lane selects active low for accessed bytes, floated in bus hold.
// - select 3 covers d31..24, down to select 0 for d7..0.
// - d7..0 is least significant byte, d31..24 most significant.
// - write data driven from second clock of the cycle onward.
// - one parity bit per byte generated on every write with data timing.
// - read parity only feeds the status, never read data or flow.
// - lane parity driven high-active on writes from the second clock onward.
// - parity status appears the clock after ready for the data just sampled.
// - status low means parity error, high means none.
// - only lanes enabled by selects and bus width are checked.
// - status valid one clock after read data, otherwise high, never floated.
`timescale 1ns/1ps
`include "blp_defs.svh"
module blp_bus_lane_parity #(
  parameter int LANES  = `BLP_LANES,
  parameter int LANE_W = `BLP_LANE_W
) (
  // clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          sys_rst_in,
  // core request side
  input  wire blp_pkg::blp_req_s             req_in,
  input  wire logic                          cycle_end_in,
  input  wire logic [1:0]                    bus_width_in,
  // hold controls
  input  wire logic                          bus_hold_in,
  input  wire logic                          addr_hold_in,
  // snoop side
  input  wire logic                          snoop_strobe_in,
  input  wire logic [`BLP_WORD_ADDR_W-1:0]   word_address_lines_in,
  // read data side
  input  wire logic                          ready_in,
  input  wire logic [`BLP_DATA_W-1:0]        data_in,
  input  wire logic [`BLP_LANES-1:0]         lane_parity_in,
  // bus outputs
  output blp_pkg::blp_bus_out_s              bus_out,
  output logic                               parity_check_result_n_out,
  output logic [`BLP_DATA_W-1:0]             read_data_out,
  output logic                               read_valid_out,
  output logic                               snoop_valid_out,
  output logic [`BLP_LINE_ADDR_W-1:0]        snoop_line_addr_out
);
  import blp_pkg::*;

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  if (LANES * LANE_W != `BLP_DATA_W || LANES != 4) begin : g_bad_param
    $error("blp_bus_lane_parity: lane geometry must cover the 32-bit bus");
  end

  // ***************************************************************
  // cycle sequencing
  // ***************************************************************
  blp_state_e              state;
  blp_state_e              next_state;
  logic                    cyc_write;
  logic                    rd_pending;
  logic [`BLP_LANES-1:0]   rd_lane_en;
  logic                    next_parity_check_result_n_n;
  logic                    par_err;
  logic [`BLP_LANES-1:0]   gen_parity;
  logic [`BLP_LANES-1:0]   width_en;
  logic [`BLP_LANES-1:0]   check_en;
  logic                    drive_wdata;
  logic                    float_addr;
  logic                    float_be;

  // state walks idle -> first clock (addr) -> later clocks (data) until cycle end
  always_comb begin
    next_state = state;
    case (state)
      BLP_IDLE: begin
        if (req_in.start && !bus_hold_in) begin
          next_state = BLP_ADDR;
        end
      end
      BLP_ADDR: begin
        next_state = cycle_end_in ? BLP_IDLE : BLP_DATA;
      end
      BLP_DATA: begin
        if (cycle_end_in) begin
          next_state = BLP_IDLE;
        end
      end
      default: begin
        next_state = BLP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= BLP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ***************************************************************
  // decode of drive windows and lane enables
  // ***************************************************************
  // data and parity launched from the edge that enters the second clock
  assign drive_wdata = cyc_write && (next_state == BLP_DATA);
  assign float_addr  = bus_hold_in || addr_hold_in;
  assign float_be    = bus_hold_in;
  // narrow bus: only low lanes carry data, so upper lanes must not raise errors
  assign width_en    = (bus_width_in == `BLP_WIDTH_8)  ? 4'h1 :
                       (bus_width_in == `BLP_WIDTH_16) ? 4'h3 : 4'hF;
  assign check_en    = rd_lane_en & width_en;
  assign next_parity_check_result_n_n = (rd_pending && ready_in) ? ~par_err : `BLP_PARITY_CHECK_RESULT_N_IDLE;

  // ***************************************************************
  // parity generation and checking
  // ***************************************************************
  // one instance shared: write data in a write cycle, returned data otherwise
  blp_lane_parity #(
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_par (
    .data_in        (cyc_write ? req_in.wdata : data_in),
    .parity_in      (lane_parity_in),
    .lane_enable_in (check_en),
    .parity_out     (gen_parity),
    .error_out      (par_err)
  );

  // ***************************************************************
  // cycle context registers
  // ***************************************************************
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cyc_write  <= 1'b0;
      rd_pending <= 1'b0;
      rd_lane_en <= 4'h0;
    end else if (state == BLP_IDLE && next_state == BLP_ADDR) begin
      cyc_write  <= req_in.write;
      rd_pending <= !req_in.write;
      rd_lane_en <= ~req_in.byte_lane_select_n;
    end else if (next_state == BLP_IDLE) begin
      cyc_write  <= 1'b0;
      rd_pending <= 1'b0;
    end
  end

  // ***************************************************************
  // address and byte lane outputs
  // ***************************************************************
  // selects stay at their idle high between cycles so no lane looks active
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_out.word_address_lines <= '0;
      bus_out.addr_oe_n          <= 1'b1;
      bus_out.byte_lane_select_n <= `BLP_BE_IDLE;
      bus_out.be_oe_n            <= 1'b1;
    end else begin
      if (state == BLP_IDLE && next_state == BLP_ADDR) begin
        bus_out.word_address_lines <= req_in.word_addr;
        bus_out.byte_lane_select_n <= req_in.byte_lane_select_n;
      end else if (next_state == BLP_IDLE) begin
        bus_out.byte_lane_select_n <= `BLP_BE_IDLE;
      end
      bus_out.addr_oe_n <= float_addr;
      bus_out.be_oe_n   <= float_be;
    end
  end

  // ***************************************************************
  // write data and lane parity outputs
  // ***************************************************************
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_out.data        <= '0;
      bus_out.lane_parity <= '0;
      bus_out.data_oe_n   <= 1'b1;
    end else begin
      bus_out.data_oe_n <= ~drive_wdata;
      if (drive_wdata) begin
        bus_out.data        <= req_in.wdata;
        bus_out.lane_parity <= gen_parity;
      end
    end
  end

  // ***************************************************************
  // read data and parity status
  // ***************************************************************
  // read data passes untouched; parity only reaches the status flop
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      parity_check_result_n_out <= `BLP_PARITY_CHECK_RESULT_N_IDLE;
      read_data_out             <= '0;
      read_valid_out            <= 1'b0;
    end else begin
      parity_check_result_n_out <= next_parity_check_result_n_n;
      read_valid_out            <= rd_pending && ready_in;
      if (rd_pending && ready_in) begin
        read_data_out <= data_in;
      end
    end
  end

  // ***************************************************************
  // inward snoop address
  // ***************************************************************
  // only bits 31..4 are taken; the line is 16 bytes so 3..2 do not matter
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      snoop_valid_out     <= 1'b0;
      snoop_line_addr_out <= '0;
    end else begin
      snoop_valid_out <= snoop_strobe_in;
      if (snoop_strobe_in) begin
        snoop_line_addr_out <= word_address_lines_in[`BLP_WORD_ADDR_W-1 -: `BLP_LINE_ADDR_W];
      end
    end
  end

endmodule

/* File: verilog/blp_defs.svh */
// blp_defs.svh: widths, lane layout and timing counts for the byte-lane parity block
// assumes: included by bare name from the package and design modules
`ifndef BLP_DEFS_SVH
`define BLP_DEFS_SVH

`define BLP_DATA_W        32
`define BLP_LANES         4
`define BLP_LANE_W        8
`define BLP_ADDR_HI       31
`define BLP_ADDR_LO       2
`define BLP_SNOOP_LO      4
`define BLP_WORD_ADDR_W   30
`define BLP_LINE_ADDR_W   28
`define BLP_PARITY_CHECK_RESULT_N_IDLE     1'h1
`define BLP_BE_IDLE       4'hF
`define BLP_WDRIVE_CLK    2
// bus width codes
`define BLP_WIDTH_32      2'h0
`define BLP_WIDTH_16      2'h1
`define BLP_WIDTH_8       2'h2

`endif

/* File: verilog/blp_pkg.sv */
// blp_pkg.sv: types shared by the byte-lane parity design
// assumes: blp_defs.svh is on the include path
`include "blp_defs.svh"
package blp_pkg;

  typedef logic [`BLP_LANES-1:0] blp_lanes_t;

  // cycle request from the core
  typedef struct packed {
    logic                          start;
    logic                          write;
    logic [`BLP_WORD_ADDR_W-1:0]   word_addr;
    blp_lanes_t                    byte_lane_select_n;
    logic [`BLP_DATA_W-1:0]        wdata;
  } blp_req_s;

  // bus-side output group with enables (enable low = driving)
  typedef struct packed {
    logic [`BLP_WORD_ADDR_W-1:0]   word_address_lines;
    logic                          addr_oe_n;
    blp_lanes_t                    byte_lane_select_n;
    logic                          be_oe_n;
    logic [`BLP_DATA_W-1:0]        data;
    blp_lanes_t                    lane_parity;
    logic                          data_oe_n;
  } blp_bus_out_s;

  typedef enum logic [1:0] {
    BLP_IDLE,
    BLP_ADDR,
    BLP_DATA
  } blp_state_e;

endpackage

/* File: verilog/blp_lane_parity.sv */
// blp_lane_parity.sv: even-parity generator and masked checker for all byte lanes
// assumes: purely combinational; caller registers results
`timescale 1ns/1ps
`include "blp_defs.svh"
module blp_lane_parity #(
  parameter int LANES  = `BLP_LANES,
  parameter int LANE_W = `BLP_LANE_W
) (
  // data and parity
  input  wire logic [LANES*LANE_W-1:0] data_in,
  input  wire logic [LANES-1:0]        parity_in,
  input  wire logic [LANES-1:0]        lane_enable_in,
  // results
  output logic [LANES-1:0]             parity_out,
  output logic                         error_out
);
  logic [LANES-1:0] lane_bad;

  // one generator per lane; lane 0 is d7..0, lane 3 is d31..24
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign parity_out[g] = ^data_in[g*LANE_W +: LANE_W];
    assign lane_bad[g]   = lane_enable_in[g] & (parity_out[g] ^ parity_in[g]);
  end
  assign error_out = |lane_bad;
endmodule

/* File: sim/blp_bus_lane_parity_asserts.sv */
// checker: timing and parity relations at the byte-lane parity block's ports
// assumes: bound to blp_bus_lane_parity; one clock, asynchronous high reset
`timescale 1ns/1ps
module blp_bus_lane_parity_asserts #(parameter int LANES = 4, parameter int LANE_W = 8) (
  // clock and reset
  input wire logic                  core_clk_in,
  input wire logic                  sys_rst_in,
  // inputs
  input wire blp_pkg::blp_req_s     req_in,
  input wire logic                  cycle_end_in,
  input wire logic [1:0]            bus_width_in,
  input wire logic                  bus_hold_in,
  input wire logic                  addr_hold_in,
  input wire logic                  snoop_strobe_in,
  input wire logic [29:0]           word_address_lines_in,
  input wire logic                  ready_in,
  input wire logic [31:0]           data_in,
  input wire logic [3:0]            lane_parity_in,
  // outputs
  input wire blp_pkg::blp_bus_out_s bus_out,
  input wire logic                  parity_check_result_n_out,
  input wire logic [31:0]           read_data_out,
  input wire logic                  read_valid_out,
  input wire logic                  snoop_valid_out,
  input wire logic [27:0]           snoop_line_addr_out
);
  import blp_pkg::*;
  // ****************
  // port relations
  // ****************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // lanes the width lets the status see; code 3 reads as full width
  wire logic [3:0] wmask = bus_width_in == 2'h1 ? 4'h3 : bus_width_in == 2'h2 ? 4'h1 : 4'hF;
  function automatic logic [3:0] ev(input logic [31:0] d);
    for (int i = 0; i < 4; i++) ev[i] = ^d[8*i+:8];
  endfunction
  parity_check_result_n_idle_a:
    assert property (!read_valid_out |-> parity_check_result_n_out) else $error("status low off status clock");
  status_cause_a:
    assert property (read_valid_out |-> $past(ready_in)) else $error("status without ready");
  rdata_kept_a:
    assert property (read_valid_out |-> read_data_out == $past(data_in)) else $error("read data altered");
  parity_check_result_n_value_a:
    assert property (read_valid_out |-> parity_check_result_n_out == !(|(($past(lane_parity_in) ^ ev($past(data_in)))
      & ~$past(bus_out.byte_lane_select_n) & $past(wmask)))) else $error("wrong parity status");
  hold_float_a:
    assert property (bus_hold_in |=> bus_out.addr_oe_n && bus_out.be_oe_n) else $error("driven in bus hold");
  ahold_float_a:
    assert property (addr_hold_in |=> bus_out.addr_oe_n) else $error("address driven in address hold");
  wpar_even_a:
    assert property (!bus_out.data_oe_n |-> bus_out.lane_parity == ev(bus_out.data)) else $error("write parity odd");
  wdrive_start_a:
    assert property ($fell(bus_out.data_oe_n) |-> $past(req_in.start, 2) && $past(req_in.write, 2))
      else $error("write data not from second clock");
  snoop_addr_a:
    assert property (snoop_strobe_in |=> snoop_valid_out && {2'h0, snoop_line_addr_out} ==
      $past(word_address_lines_in) >> 2) else $error("snoop line address wrong");
  sel_release_a:
    assert property (cycle_end_in |=> bus_out.byte_lane_select_n == 4'hF) else $error("selects kept after end");
  cover property (read_valid_out && !parity_check_result_n_out);
  cover property ($fell(bus_out.data_oe_n));
  cover property (snoop_valid_out);
endmodule

bind blp_bus_lane_parity blp_bus_lane_parity_asserts #(.LANES(LANES), .LANE_W(LANE_W)) chk_inst (
  .core_clk_in, .sys_rst_in, .req_in, .cycle_end_in, .bus_width_in, .bus_hold_in, .addr_hold_in,
  .snoop_strobe_in, .word_address_lines_in, .ready_in, .data_in, .lane_parity_in, .bus_out,
  .parity_check_result_n_out, .read_data_out, .read_valid_out, .snoop_valid_out, .snoop_line_addr_out);

/* File: sim/blp_sys_model.sv */
// partner: system controller answering each cycle with ready and read data
// assumes: watches the block's bus outputs; bench sets wait, data and parity faults
`timescale 1ns/1ps
module blp_sys_model (
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  sys_rst_in,
  // bench controls
  input  wire logic [3:0]            wait_in,
  input  wire logic [31:0]           rdata_in,
  input  wire logic [3:0]            bad_lane_in,
  // watched bus
  input  wire blp_pkg::blp_bus_out_s bus_in,
  // answer
  output logic                       ready_out,
  output logic                       cycle_end_out,
  output logic [31:0]                data_out,
  output logic [3:0]                 parity_out
);
  import blp_pkg::*;
  logic [3:0] cnt;
  // ****************
  // answer logic
  // ****************
  // a cycle is in flight while selects are driven and not all idle
  wire logic busy = !bus_in.be_oe_n && bus_in.byte_lane_select_n != 4'hF;
  assign cycle_end_out = ready_out;
  // released data flips each clock so a stale copy never passes for an answer
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt        <= 4'h0;
      ready_out  <= 1'b0;
      data_out   <= 32'h0;
      parity_out <= 4'h0;
    end else if (busy && !ready_out && cnt == wait_in) begin
      ready_out  <= 1'b1;
      data_out   <= rdata_in; // all four lanes carry data
      for (int i = 0; i < 4; i++) parity_out[i] <= ^rdata_in[8*i+:8] ^ bad_lane_in[i];
    end else begin
      ready_out  <= 1'b0;
      cnt        <= (busy && !ready_out) ? cnt + 4'h1 : 4'h0;
      data_out   <= ~data_out;
      parity_out <= ~parity_out;
    end
  end
endmodule

/* File: sim/bus_byte_lane_parity_test.sv */
// bench: random core cycles, hold and snoop; outputs compared with a bench model
// assumes: design, package, checker and partner model compiled before this file
`timescale 1ns/1ps
module bus_byte_lane_parity_test;
  import blp_pkg::*;
  logic         core_clk, cyc_end, ready, parity_check_result_n_n, rvalid, svalid;
  logic         sys_rst = 1'b1, hold = 1'b0, ahold = 1'b0, strobe = 1'b0;
  blp_req_s     req = '0;
  blp_bus_out_s bus;
  logic [1:0]   width = 2'h0;
  logic [29:0]  snoop_addr = 30'h0;
  logic [31:0]  rdata = 32'h0, dbus, rd_out;
  logic [3:0]   wait_n = 4'h0, bad = 4'h0, dpar;
  logic [27:0]  line_addr;
  int           mismatches = 0, check_count = 0, cyc = 0, seed = 32'h991c;
  blp_bus_lane_parity blp_bus_lane_parity_inst (
    .core_clk_in(core_clk), .sys_rst_in(sys_rst), .req_in(req), .cycle_end_in(cyc_end),
    .bus_width_in(width), .bus_hold_in(hold), .addr_hold_in(ahold), .snoop_strobe_in(strobe),
    .word_address_lines_in(snoop_addr), .ready_in(ready), .data_in(dbus), .lane_parity_in(dpar), .bus_out(bus),
    .parity_check_result_n_out(parity_check_result_n_n), .read_data_out(rd_out), .read_valid_out(rvalid),
    .snoop_valid_out(svalid), .snoop_line_addr_out(line_addr));
  blp_sys_model blp_sys_model_inst (
    .core_clk_in(core_clk), .sys_rst_in(sys_rst), .wait_in(wait_n), .rdata_in(rdata), .bad_lane_in(bad),
    .bus_in(bus), .ready_out(ready), .cycle_end_out(cyc_end), .data_out(dbus), .parity_out(dpar));
  // ****************
  // helpers
  // ****************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string msg);
    chk_word({31'h0, got}, {31'h0, exp}, msg);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // a hang costs one mismatch; the run needs about a hundred clocks
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      close_out();
    end
  end
  function automatic logic [3:0] ev(input logic [31:0] d);
    for (int i = 0; i < 4; i++) ev[i] = ^d[8*i+:8];
  endfunction
  // one core cycle with random lanes, wait, width and parity faults
  task automatic run_cycle(input logic wr);
    logic [3:0]  sel;
    logic [3:0]  en;
    logic [29:0] ad;
    logic [31:0] wd;
    sel = 4'($random(seed));
    if (sel == 4'hF) sel = 4'hE;
    ad = 30'($random(seed));
    wd = $random(seed);
    rdata = $random(seed);
    bad = 4'($random(seed));
    wait_n = 4'($random(seed)) & 4'h3;
    width = 2'($random(seed));
    en = width == 2'h1 ? 4'h3 : width == 2'h2 ? 4'h1 : 4'hF;
    req = '{1'b1, wr, ad, sel, wd};
    @(negedge core_clk);
    req.start = 1'b0;
    chk_word({2'h0, bus.word_address_lines}, {2'h0, ad}, "address");
    chk_word({28'h0, bus.byte_lane_select_n}, {28'h0, sel}, "selects");
    @(negedge core_clk);
    if (wr) begin
      chk_word(bus.data, wd, "write data");
      chk_word({28'h0, bus.lane_parity}, {28'h0, ev(wd)}, "write parity");
      chk_flag(bus.data_oe_n, 1'b0, "data drive");
    end
    for (int k = 0; k < 12 && bus.byte_lane_select_n !== 4'hF; k++) @(negedge core_clk);
    chk_flag(rvalid, !wr, "read valid");
    chk_flag(parity_check_result_n_n, wr | !(|(bad & ~sel & en)), "parity status");
    if (!wr) chk_word(rd_out, rdata, "read data");
    @(negedge core_clk);
    chk_flag(parity_check_result_n_n, 1'b1, "status idle");
    chk_flag(bus.data_oe_n, 1'b1, "data released");
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int n = 0; n < 14; n++) run_cycle(n[0]);
    hold = 1'b1;
    req = '{1'b1, 1'b0, 30'h0, 4'h0, 32'h0};
    repeat (2) @(negedge core_clk);
    chk_flag(bus.addr_oe_n, 1'b1, "address float");
    chk_flag(bus.be_oe_n, 1'b1, "select float");
    chk_word({28'h0, bus.byte_lane_select_n}, 32'hF, "start in hold refused");
    req.start = 1'b0;
    hold = 1'b0;
    ahold = 1'b1;
    repeat (2) @(negedge core_clk);
    chk_flag(bus.addr_oe_n, 1'b1, "address hold float");
    chk_flag(bus.be_oe_n, 1'b0, "selects kept");
    ahold = 1'b0;
    for (int n = 0; n < 3; n++) begin
      snoop_addr = 30'($random(seed));
      strobe = 1'b1;
      @(negedge core_clk);
      strobe = 1'b0;
      chk_flag(svalid, 1'b1, "snoop valid");
      chk_word({4'h0, line_addr}, {4'h0, snoop_addr[29:2]}, "snoop line");
    end
    close_out();
  end
endmodule
